// [bench/uart_host_bus_interface_test.sv]
// bench for the uart host bus interface, one instance per bus mode
// assumes inputs shared by both instances; each ignores the other mode's bus
module uart_host_bus_interface_test;
  timeunit 1ns;
  timeprecision 1ns;
  import uhb_pkg::*;
  localparam int unsigned BC = 4;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic write_n = 1'b1;
  logic read_n = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] writedata = 8'h00;
  logic [7:0] hwdata = 8'h00;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [5:0] haddr = 6'h00;
  logic [1:0] htrans = 2'h0;
  logic [1:0] hsize = 2'h0;
  logic accept = 1'b0;
  logic link_up = 1'b0;
  logic irq, txd, dtr_n, rts_n, rxd, cts_n, dsr_n, dtr_a, hreadyo;
  logic [7:0] readdata, hrdata;
  logic [1:0] hresp;
  int failures = 0;
  int checks_done = 0;

  // ****************
  // clock, design and partner
  // ****************
  initial forever #25 ref_clk = ~ref_clk;
  // short bit time keeps frames to a few dozen cycles
  uhb_top #(.BUS_MODE(MODE_PERIPH), .BIT_CYC(BC)) i_dut (
    .ref_clk, .rst_n, .irq, .sel, .addr, .write_n, .read_n, .writedata, .readdata,
    .hsel, .haddr, .hwrite, .htrans, .hsize, .hreadyi(hreadyo), .hreadyo(),
    .hresp(), .hrdata(), .hwdata, .txd, .rxd, .dtr_n, .rts_n, .dsr_n, .cts_n);
  // modem option off on the ahb copy, so its modem outputs must stay high
  uhb_top #(.BUS_MODE(MODE_AHB), .MODEM_EN(1'b0), .BIT_CYC(BC)) i_dut_ahb (
    .ref_clk, .rst_n, .irq(), .sel, .addr, .write_n, .read_n, .writedata,
    .readdata(), .hsel, .haddr, .hwrite, .htrans, .hsize, .hreadyi(hreadyo),
    .hreadyo, .hresp, .hrdata, .hwdata, .txd(), .rxd, .dtr_n(dtr_a), .rts_n(),
    .dsr_n, .cts_n);
  uhb_peer #(.BIT_CYC(BC)) i_peer (
    .ref_clk, .txd, .accept, .link_up, .rxd, .cts_n, .dsr_n);

  // ****************
  // bus tasks
  // ****************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // peripheral write; both set drops read_n too, which must be refused
  task automatic pw(input logic [3:0] a, input logic [7:0] d, input logic both = 1'b0);
    @(negedge ref_clk);
    sel = 1'b1;
    addr = a;
    writedata = d;
    write_n = 1'b0;
    read_n = ~both;
    @(negedge ref_clk);
    sel = 1'b0;
    write_n = 1'b1;
    read_n = 1'b1;
  endtask

  // peripheral read, data judged 1 ns after the address is driven, half a cycle before the sampling edge
  task automatic pr(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(negedge ref_clk);
    sel = 1'b1;
    addr = a;
    read_n = 1'b0;
    #1 chk(what, exp, readdata);
    @(negedge ref_clk);
    sel = 1'b0;
    read_n = 1'b1;
  endtask

  // one ahb beat: address phase, wait cycle, completing cycle, one idle cycle
  task automatic ahb(input logic [5:0] a, input logic wr, input logic [1:0] sz,
                     input logic [7:0] d, input logic [1:0] er, input logic [7:0] ed);
    @(negedge ref_clk);
    hsel = 1'b1;
    haddr = a;
    hwrite = wr;
    hsize = sz;
    htrans = 2'h2;
    @(negedge ref_clk);
    hsel = 1'b0;
    htrans = 2'h0;
    hwdata = d;
    chk("wait cycle ready", 8'h00, {7'h0, hreadyo});
    chk("first resp", {6'h0, er}, {6'h0, hresp});
    @(negedge ref_clk);
    chk("done ready", 8'h01, {7'h0, hreadyo});
    chk("second resp", {6'h0, er}, {6'h0, hresp});
    chk("read data", wr ? 8'h00 : ed, hrdata);
    @(negedge ref_clk);
    chk("read data after", 8'h00, hrdata);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    chk("txd", 8'h01, {7'h0, txd});
    chk("dtr_n", 8'h01, {7'h0, dtr_n});
    chk("irq", 8'h00, {7'h0, irq});
    chk("hreadyo", 8'h01, {7'h0, hreadyo});
    chk("hrdata", 8'h00, hrdata);
    $display("test reset done");
  endtask

  task automatic t_periph();
    pw(IDX_MCR, 8'h03);
    @(negedge ref_clk);
    chk("dtr_n on", 8'h00, {7'h0, dtr_n});
    chk("rts_n on", 8'h00, {7'h0, rts_n});
    addr = IDX_TSR;
    #1 chk("tsr without strobes", 8'h00, readdata);
    @(negedge ref_clk);
    addr = IDX_MCR;
    #1 chk("mcr without strobes", 8'h03, readdata);
    pw(IDX_MCR, 8'h00, 1'b1);
    pr(IDX_MCR, 8'h03, "mcr after refused write");
    link_up = 1'b1;
    repeat (4) @(negedge ref_clk);
    pr(IDX_MSR, 8'h01, "msr peer ready");
    link_up = 1'b0;
    $display("test peripheral done");
  endtask

  // peer stalls, fifo overfills, then drains; idle raises the interrupt
  task automatic t_fifo();
    pw(IDX_MCR, 8'h04);
    for (int i = 0; i < 5; i++) pw(IDX_TD, 8'hA0 + 8'(i));
    pr(IDX_TSR, 8'h04, "tsr level full");
    accept = 1'b1;
    for (int n = 0; n < 400 && irq !== 1'b1; n++) @(negedge ref_clk);
    chk("frames seen", 8'h04, 8'(i_peer.got.size()));
    for (int i = 0; i < 4; i++) chk("frame byte", 8'hA0 + 8'(i), i_peer.got[i]);
    chk("bad stop bits", 8'h00, 8'(i_peer.bad_stop));
    chk("irq raised", 8'h01, {7'h0, irq});
    pw(IDX_MCR, 8'h00);
    @(negedge ref_clk);
    chk("irq masked", 8'h00, {7'h0, irq});
    pw(IDX_MCR, 8'h04);
    pr(IDX_TSR, 8'h80, "tsr idle");
    @(negedge ref_clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    $display("test fifo done");
  endtask

  task automatic t_ahb();
    ahb(6'h2C, 1'b1, 2'h0, 8'h03, HRESP_OKAY, 8'h00);
    chk("ahb dtr_n", 8'h01, {7'h0, dtr_a});
    for (int s = 0; s < 3; s++) ahb(6'h2C, 1'b0, 2'(s), 8'h00, HRESP_OKAY, 8'h03);
    for (int l = 1; l < 4; l++) ahb(6'h2C | 6'(l), 1'b1, 2'h0, 8'h00, HRESP_ERROR, 8'h00);
    ahb(6'h2C, 1'b1, HSIZE_DWORD, 8'h00, HRESP_ERROR, 8'h00);
    ahb(6'h2C, 1'b0, 2'h2, 8'h00, HRESP_OKAY, 8'h03);
    $display("test ahb done");
  endtask

  // ****************
  // run control
  // ****************
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge ref_clk);
    t_reset();
    rst_n = 1'b1;
    t_periph();
    t_fifo();
    t_ahb();
    end_of_test();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #(50 * 4000);
    failures++;
    $display("watchdog ran out");
    end_of_test();
  end
endmodule

// [bench/uhb_peer.sv]
// serial peer model facing the block's serial and modem pins
// assumes 8 data bits, lsb first, one stop bit, BIT_CYC ref_clk cycles per bit
module uhb_peer #(
  parameter int unsigned BIT_CYC = 4
) (
  input wire logic ref_clk,
  input wire logic txd,
  input wire logic accept,
  input wire logic link_up,
  output logic rxd,
  output logic cts_n,
  output logic dsr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  int bad_stop = 0;

  // ****************
  // peer lines
  // ****************
  // rxd is driven by a constant assign and this peer never sends, so it idles high
  assign rxd = 1'b1;
  assign cts_n = ~accept;
  assign dsr_n = ~link_up;

  // frame catcher, samples each bit near its centre on the falling edge,
  // away from the rising edge that launches txd
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(negedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(negedge ref_clk);
        b[i] = txd;
      end
      repeat (BIT_CYC) @(negedge ref_clk);
      if (txd !== 1'b1) bad_stop++;
      got.push_back(b);
    end
  end
endmodule

// [logic/uhb_top.sv]
// uart host bus interface: peripheral or ahb slave, tx fifo, serial and modem pins
// assumes bus inputs synchronous to ref_clk; modem inputs may be asynchronous

// ************************
// small valid/ready fifo
// ************************
module uhb_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(D+1)-1:0] level
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [$clog2(D+1)-1:0] cnt_q;
  logic push, pop;

  // refuse depths that the wrapping pointers cannot serve
  if (D < 2 || (D & (D - 1)) != 0) begin : g_depth_chk
    $error("fifo depth must be a power of two");
  end

  // full and empty straight from the count
  assign in_ready = (cnt_q != ($bits(cnt_q))'(D));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rp_q];
  assign level = cnt_q;

  // storage, no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ************************
// top level
// ************************
module uhb_top
  import uhb_pkg::*;
#(
  parameter bit BUS_MODE = uhb_pkg::MODE_PERIPH,
  parameter bit MODEM_EN = 1'b1,
  parameter int unsigned BIT_CYC = uhb_pkg::BIT_CYC_DEF,
  parameter int unsigned FIFO_D = uhb_pkg::FIFO_D_DEF
) (
  input wire logic ref_clk, // single rising-edge clock
  input wire logic rst_n,
  output logic irq,
  input wire logic sel,
  input wire logic [3:0] addr,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic [7:0] writedata,
  output logic [7:0] readdata,
  input wire logic hsel,
  input wire logic [5:0] haddr,
  input wire logic hwrite,
  input wire logic [1:0] htrans,
  input wire logic [1:0] hsize,
  input wire logic hreadyi,
  output logic hreadyo,
  output logic [1:0] hresp,
  output logic [7:0] hrdata,
  input wire logic [7:0] hwdata,
  output logic txd,
  input wire logic rxd,
  output logic dtr_n,
  output logic rts_n,
  input wire logic dsr_n,
  input wire logic cts_n
);
  import uhb_pkg::*;

  localparam int unsigned LW = $clog2(FIFO_D + 1);

  if (BIT_CYC < 2) begin : g_bit_chk
    $error("bit time must span at least two cycles");
  end
  if (LW > 5) begin : g_lvl_chk
    $error("fifo level does not fit the status field");
  end

  // ************************
  // register read mux
  // ************************
  function automatic logic [7:0] rd_mux(input logic [3:0] idx, input logic [7:0] tsr,
                                        input logic [7:0] mcr, input logic [7:0] msr);
    logic [7:0] r;
    r = 8'h00;
    if (idx == IDX_TSR) r = tsr;
    if (idx == IDX_MCR) r = mcr;
    if (idx == IDX_MSR) r = msr;
    return r;
  endfunction

  logic [2:0] mcr_q;
  logic idle_flag_q;
  logic [LW-1:0] lvl;
  logic dsr_meta_q, dsr_q, cts_meta_q, cts_q;
  logic [7:0] tsr_v, mcr_v, msr_v;

  assign tsr_v = {idle_flag_q, 2'h0, 5'(lvl)};
  assign mcr_v = {5'h00, mcr_q};
  assign msr_v = {6'h00, ~cts_q, ~dsr_q};

  // ************************
  // modem synchronisers
  // ************************
  // meta stage feeds only the second stage; idle high when option is off
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dsr_meta_q <= 1'b1;
      dsr_q <= 1'b1;
      cts_meta_q <= 1'b1;
      cts_q <= 1'b1;
    end else begin
      dsr_meta_q <= MODEM_EN ? dsr_n : 1'b1;
      dsr_q <= dsr_meta_q;
      cts_meta_q <= MODEM_EN ? cts_n : 1'b1;
      cts_q <= cts_meta_q;
    end
  end

  // ************************
  // peripheral decode
  // ************************
  logic per_wr, per_rd;
  assign per_wr = (BUS_MODE == MODE_PERIPH) && sel && !write_n && read_n;
  assign per_rd = (BUS_MODE == MODE_PERIPH) && sel && !read_n && write_n;
  // no wait state possible here, so this path stays combinational
  assign readdata = (BUS_MODE == MODE_PERIPH) ? rd_mux(addr, tsr_v, mcr_v, msr_v) : 8'h00;

  // ************************
  // ahb slave
  // ************************
  uhb_ahb_st_e ah_st_q, ah_st_d;
  logic ah_acc, ah_err_new, ah_err_q, ah_wr_q;
  logic [3:0] ah_idx_q;
  logic ah_wr, ah_rd;

  // burst and protection inputs are not ports at all; each beat stands alone
  assign ah_acc = (BUS_MODE == MODE_AHB) && hsel && htrans[HTRANS_ACTIVE]
                  && hreadyi && (ah_st_q != UHB_AH_WAIT);
  assign ah_err_new = (haddr[1:0] != HADDR_LOW_OK) || (hsize == HSIZE_DWORD);
  assign ah_wr = (ah_st_q == UHB_AH_WAIT) && ah_wr_q && !ah_err_q;
  assign ah_rd = (ah_st_q == UHB_AH_WAIT) && !ah_wr_q && !ah_err_q;

  // next state: one wait cycle, then the completing cycle
  always_comb begin
    ah_st_d = UHB_AH_IDLE;
    unique case (ah_st_q)
      UHB_AH_WAIT: ah_st_d = UHB_AH_LAST;
      UHB_AH_IDLE, UHB_AH_LAST: ah_st_d = ah_acc ? UHB_AH_WAIT : UHB_AH_IDLE;
      default: ah_st_d = UHB_AH_IDLE;
    endcase
  end

  // address phase capture and response drive
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ah_st_q <= UHB_AH_IDLE;
      ah_err_q <= 1'b0;
      ah_wr_q <= 1'b0;
      ah_idx_q <= 4'h0;
      hreadyo <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      ah_st_q <= ah_st_d;
      if (ah_acc) begin
        ah_err_q <= ah_err_new;
        ah_wr_q <= hwrite;
        ah_idx_q <= haddr[5:2];
      end
      hreadyo <= (ah_st_d != UHB_AH_WAIT);
      // two-cycle error: low ready first, then high ready
      if (ah_st_d == UHB_AH_WAIT) hresp <= ah_err_new ? HRESP_ERROR : HRESP_OKAY;
      else if (ah_st_d == UHB_AH_IDLE) hresp <= HRESP_OKAY;
    end
  end

  // read data only in the completing cycle, zero otherwise for or-muxing
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata <= 8'h00;
    end else begin
      hrdata <= ah_rd ? rd_mux(ah_idx_q, tsr_v, mcr_v, msr_v) : 8'h00;
    end
  end

  // ************************
  // common access strobes
  // ************************
  logic acc_wr, acc_rd;
  logic [3:0] acc_idx;
  logic [7:0] acc_wd;
  assign acc_wr = per_wr || ah_wr;
  assign acc_rd = per_rd || ah_rd;
  assign acc_idx = (BUS_MODE == MODE_AHB) ? ah_idx_q : addr;
  assign acc_wd = (BUS_MODE == MODE_AHB) ? hwdata : writedata;

  // modem control, written on the access edge itself
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mcr_q <= MCR_RST;
    end else if (acc_wr && acc_idx == IDX_MCR) begin
      mcr_q <= acc_wd[2:0];
    end
  end

  // ************************
  // transmit fifo and shifter
  // ************************
  logic [7:0] fifo_dout;
  logic fifo_ovalid, fifo_pop, fifo_iready;
  uhb_tx_st_e tx_st_q;
  logic [FRAME_BITS-1:0] sh_q;
  logic [$clog2(FRAME_BITS+1)-1:0] bits_q;
  logic [$clog2(BIT_CYC+1)-1:0] tick_q;
  logic tx_go;

  // a write while full is dropped: the bus cannot be stalled
  uhb_fifo #(.W(FIFO_W_DEF), .D(FIFO_D)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_data(acc_wd),
    .in_valid(acc_wr && acc_idx == IDX_TD),
    .in_ready(fifo_iready),
    .out_data(fifo_dout),
    .out_valid(fifo_ovalid),
    .out_ready(fifo_pop),
    .level(lvl)
  );

  // peer flow control holds the queue when modem option is on
  assign tx_go = fifo_ovalid && (!MODEM_EN || !cts_q);
  assign fifo_pop = (tx_st_q == UHB_TX_IDLE) && tx_go;

  // frame shifter: start, eight data lsb first, stop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_st_q <= UHB_TX_IDLE;
      sh_q <= '1;
      bits_q <= '0;
      tick_q <= '0;
      txd <= 1'b1;
    end else begin
      unique case (tx_st_q)
        UHB_TX_IDLE: begin
          txd <= 1'b1;
          if (tx_go) begin
            sh_q <= {1'b1, fifo_dout, 1'b0};
            bits_q <= '0;
            tick_q <= '0;
            tx_st_q <= UHB_TX_SHIFT;
          end
        end
        UHB_TX_SHIFT: begin
          txd <= sh_q[0];
          if (tick_q == ($bits(tick_q))'(BIT_CYC - 1)) begin
            tick_q <= '0;
            sh_q <= {1'b1, sh_q[FRAME_BITS-1:1]};
            if (bits_q == ($bits(bits_q))'(FRAME_BITS - 1)) tx_st_q <= UHB_TX_IDLE;
            else bits_q <= bits_q + 1'b1;
          end else begin
            tick_q <= tick_q + 1'b1;
          end
        end
      endcase
    end
  end

  // ************************
  // idle flag, interrupt and modem outputs
  // ************************
  logic went_idle, flag_d;
  assign went_idle = (tx_st_q == UHB_TX_SHIFT) && (tick_q == ($bits(tick_q))'(BIT_CYC - 1))
                     && (bits_q == ($bits(bits_q))'(FRAME_BITS - 1)) && !fifo_ovalid;
  // a new idle event beats a status read in the same cycle
  assign flag_d = went_idle || (idle_flag_q && !(acc_rd && acc_idx == IDX_TSR));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      idle_flag_q <= 1'b0;
      irq <= 1'b0;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
    end else begin
      idle_flag_q <= flag_d;
      irq <= flag_d && mcr_q[MCR_IEN];
      dtr_n <= !(MODEM_EN && mcr_q[MCR_DTR]);
      rts_n <= !(MODEM_EN && mcr_q[MCR_RTS]);
    end
  end

  // ************************
  // assertions
  // ************************
  sequence ah_beat_s;
    ah_acc ##1 !hreadyo;
  endsequence

  one_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ah_beat_s |=> hreadyo) else $error("ahb beat did not finish after one wait");
  err_resp_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ah_acc && ah_err_new |=> hresp == HRESP_ERROR ##1 hresp == HRESP_ERROR && hreadyo)
    else $error("misaligned or double word beat not answered with error");
  err_noeffect_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ah_acc && ah_err_new && hwrite |=> ##1 $stable(mcr_q) && ($stable(lvl) || $past(fifo_pop)))
    else $error("errored beat changed internal state");
  rdata_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(hreadyo && $past(ah_st_q) == UHB_AH_WAIT) |-> hrdata == 8'h00)
    else $error("ahb read data not zero outside completing cycle");
  per_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    per_wr && addr == IDX_MCR |=> mcr_q == $past(writedata[2:0]))
    else $error("peripheral write not taken on its edge");
  per_rdmux_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    BUS_MODE == MODE_PERIPH && addr == IDX_MCR |-> readdata == mcr_v)
    else $error("peripheral read data not following address");
  txd_reset_a: assert property (@(posedge ref_clk)
    !rst_n |=> txd) else $error("serial output not high after reset");
  rts_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    MODEM_EN && mcr_q[MCR_RTS] |=> !rts_n) else $error("request to send not driven low");
  dtr_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    MODEM_EN && mcr_q[MCR_DTR] |=> !dtr_n) else $error("terminal ready not driven low");
  sync_lat_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    MODEM_EN ##2 1'b1 |-> msr_v[MSR_CTS] == !$past(cts_n, 2))
    else $error("clear to send status not two stages behind pin");
  irq_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    idle_flag_q && acc_rd && acc_idx == IDX_TSR && !went_idle |=> !idle_flag_q && !irq)
    else $error("status read did not clear the interrupt");
endmodule

// [shared/uhb_pkg.sv]
// constants for the uart host bus interface block
// assumes a single 20 MHz system clock shared with the bus master
package uhb_pkg;
  // ****************
  // clock and timing
  // ****************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BAUD_DEF = 115_200;
  // default bit time rounds down to whole cycles
  localparam int unsigned BIT_CYC_DEF = CLK_HZ / BAUD_DEF;
  localparam int unsigned FRAME_BITS = 10;
  localparam int unsigned FIFO_W_DEF = 8;
  localparam int unsigned FIFO_D_DEF = 4;

  // ****************
  // bus modes
  // ****************
  localparam bit MODE_PERIPH = 1'b0;
  localparam bit MODE_AHB = 1'b1;

  // ****************
  // register word indices
  // ****************
  localparam logic [3:0] IDX_TSR = 4'h3;
  localparam logic [3:0] IDX_TD = 4'h4;
  localparam logic [3:0] IDX_MCR = 4'hB;
  localparam logic [3:0] IDX_MSR = 4'hC;

  // ****************
  // field positions and reset values
  // ****************
  localparam int unsigned MCR_DTR = 0;
  localparam int unsigned MCR_RTS = 1;
  localparam int unsigned MCR_IEN = 2;
  localparam logic [2:0] MCR_RST = 3'h0;
  localparam int unsigned MSR_DSR = 0;
  localparam int unsigned MSR_CTS = 1;
  localparam int unsigned TSR_IDLE_FLAG = 7;

  // ****************
  // ahb encodings
  // ****************
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [1:0] HRESP_ERROR = 2'h1;
  localparam logic [1:0] HSIZE_DWORD = 2'h3;
  localparam logic [1:0] HADDR_LOW_OK = 2'h0;
  localparam int unsigned HTRANS_ACTIVE = 1;

  typedef enum logic [1:0] {
    UHB_AH_IDLE = 2'b00,
    UHB_AH_WAIT = 2'b01,
    UHB_AH_LAST = 2'b10
  } uhb_ahb_st_e;

  typedef enum logic {
    UHB_TX_IDLE = 1'b0,
    UHB_TX_SHIFT = 1'b1
  } uhb_tx_st_e;
endpackage
